// ===== hdl/cxe_pkg.sv
// Package with constants and types of the exception entry unit
package cxe_pkg;
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int VEC_W = 8;
   localparam logic [31:0] POR_PC_ADDR = 32'h0000_0000;
   localparam logic [31:0] POR_SP_ADDR = 32'h0000_0004;
   localparam logic [31:0] MAN_PC_ADDR = 32'h0000_0008;
   localparam logic [31:0] MAN_SP_ADDR = 32'h0000_000c;
   localparam logic [31:0] VBR_RESET = 32'h0000_0000;
   localparam logic [3:0] MASK_RESET = 4'hf;
   localparam logic [31:0] SR_RESET = 32'h0000_00f0;
   localparam int MASK_LSB = 4;
   localparam logic [VEC_W-1:0] VEC_GEN_ILL = 8'h04;
   localparam logic [VEC_W-1:0] VEC_SLOT_ILL = 8'h06;
   localparam logic [VEC_W-1:0] VEC_CPU_AE = 8'h09;
   localparam logic [VEC_W-1:0] VEC_DMA_AE = 8'h0a;
   localparam logic [VEC_W-1:0] VEC_NMI = 8'h0b;
   localparam logic [VEC_W-1:0] VEC_UBRK = 8'h0c;
   localparam logic [VEC_W-1:0] VEC_DBG = 8'h0d;
   localparam logic [3:0] NMI_LEVEL = 4'hf;
   localparam logic [31:0] STACK_STEP = 32'h0000_0004;

   // Exception classes from the ranker
   typedef enum logic [3:0] {
      CXE_NONE, CXE_CPU_AE, CXE_DMA_AE, CXE_NMI, CXE_UBRK, CXE_DBG, CXE_EXT,
      CXE_PERI, CXE_TRAP, CXE_GEN_ILL, CXE_SLOT_ILL
   } cxe_src_e;
endpackage : cxe_pkg

// ===== hdl/cxe_rank_if.sv
// Interface carrying raw requests to the ranker and its choice back
`timescale 1ns/10ps
interface cxe_rank_if;
   logic cpu_ae;
   logic dma_ae;
   logic nmi;
   logic ubrk;
   logic dbg;
   logic ext;
   logic peri;
   logic trap;
   logic undef;
   logic in_slot;
   logic pc_mod;
   cxe_pkg::cxe_src_e pick;
   modport ranker (input cpu_ae, dma_ae, nmi, ubrk, dbg, ext, peri, trap, undef,
      in_slot, pc_mod, output pick);
   modport user (output cpu_ae, dma_ae, nmi, ubrk, dbg, ext, peri, trap, undef,
      in_slot, pc_mod, input pick);
endinterface : cxe_rank_if

// ===== hdl/cxe_ranker.sv
// Fixed priority ranker of non-reset exception sources
`timescale 1ns/10ps
module cxe_ranker (
   cxe_rank_if.ranker rk
);
   // Category order, then order inside each category
   always_comb begin
      rk.pick = cxe_pkg::CXE_NONE;
      if (rk.cpu_ae) begin
         rk.pick = cxe_pkg::CXE_CPU_AE;
      end else if (rk.dma_ae) begin
         rk.pick = cxe_pkg::CXE_DMA_AE;
      end else if (rk.nmi) begin
         rk.pick = cxe_pkg::CXE_NMI;
      end else if (rk.ubrk) begin
         rk.pick = cxe_pkg::CXE_UBRK;
      end else if (rk.dbg) begin
         rk.pick = cxe_pkg::CXE_DBG;
      end else if (rk.ext) begin
         rk.pick = cxe_pkg::CXE_EXT;
      end else if (rk.peri) begin
         rk.pick = cxe_pkg::CXE_PERI;
      end else if (rk.trap && !rk.in_slot) begin
         rk.pick = cxe_pkg::CXE_TRAP;
      end else if (rk.undef && !rk.in_slot) begin
         rk.pick = cxe_pkg::CXE_GEN_ILL;
      end else if (rk.in_slot && (rk.undef || rk.pc_mod || rk.trap)) begin
         rk.pick = cxe_pkg::CXE_SLOT_ILL;
      end
   end
endmodule : cxe_ranker

// ===== hdl/cxe_entry.sv
// Exception recognition and entry sequencer of the core
// Functional notes
// - Simultaneous requests ranked resets, address errors, interrupts, then instructions.
// - Power-on beats manual reset; CPU address error beats DMA address error.
// - Interrupts ranked NMI, user break, debug port, external, peripheral; here the NMI request is tied low, so NMI is never taken.
// - Instruction exceptions ranked trap, general illegal, then slot illegal.
// - Clear pin rising with NMI high starts power-on reset handling.
// - Clear pin rising with NMI low starts manual reset handling.
// - CPU address errors and interrupts taken at decode, DMA address errors at any time; all started after instruction completes.
// - Trap handling starts as part of executing the trap instruction.
// - Undefined opcode outside a delay slot raises general illegal instruction.
// - Undefined or PC-modifying opcode in a delay slot raises slot illegal.
// - Jumps, calls, returns, all branches and trap count as PC-modifying.
// - Power-on reset fetches PC from address 0 and SP from 4.
// - Manual reset fetches PC from address 8 and SP from 0xc.
// - After reset fetches, vector base cleared and interrupt mask set to ones.
// - After reset initialisation, execution starts at the fetched PC.
// - Other exceptions push status word then PC onto stack before vector fetch.
// - Interrupt entry loads accepted level into mask; others leave it unchanged.
// - Non-reset vector address is vector base plus four times vector number.
`timescale 1ns/10ps
module cxe_entry #(
   parameter int AW = cxe_pkg::ADDR_W
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic chip_clear_input_n_in,
   input wire logic nmi_pin_in,
   input wire logic cpu_addr_err_in,
   input wire logic general_dma_engine_err_in,
   input wire logic network_dma_engine_err_in,
   input wire logic user_break_in,
   input wire logic debug_host_port_irq_in,
   input wire logic ext_irq_in,
   input wire logic [3:0] ext_level_in,
   input wire logic [7:0] ext_vec_in,
   input wire logic peri_irq_in,
   input wire logic [3:0] peri_level_in,
   input wire logic [7:0] peri_vec_in,
   input wire logic decode_valid_in,
   input wire logic insn_done_in,
   input wire logic software_trap_op_in,
   input wire logic [7:0] trap_imm_in,
   input wire logic undef_op_in,
   input wire logic in_delay_slot_in,
   input wire logic pc_modify_op_in,
   input wire logic [31:0] cur_pc_in,
   input wire logic [31:0] stack_gpr_in,
   input wire logic mem_done_in,
   input wire logic [31:0] mem_rdata_in,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [AW-1:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   output logic [3:0] mem_be_out,
   output logic core_hold_out,
   output logic start_valid_out,
   output logic [31:0] start_pc_out,
   output logic [31:0] stack_gpr_out,
   output logic [31:0] vector_base_reg_out,
   output logic [31:0] processor_status_word_out,
   output logic ack_out
);
   typedef enum {
      ST_IDLE, ST_WAIT, ST_RST_PC, ST_RST_SP, ST_PUSH_SR, ST_PUSH_PC, ST_VEC, ST_GO
   } cxe_state_e;

   cxe_state_e state_q;
   logic clr_q;
   logic por_q;
   logic irq_q;
   logic [3:0] lvl_q;
   logic [7:0] vec_q;
   logic [31:0] sp_q;
   logic [31:0] pc_q;
   logic [31:0] ret_pc_q;
   logic [31:0] vbr_q;
   logic [31:0] sr_q;
   logic clr_rise;
   logic take_now;
   logic [3:0] pick_lvl;
   logic [7:0] pick_vec;
   cxe_rank_if rk ();

   cxe_ranker u_rank (.rk(rk));

   // Raw requests into the ranker, gated by decode except DMA address errors and the slot qualifiers; the NMI request is tied low
   assign rk.cpu_ae = decode_valid_in && cpu_addr_err_in;
   assign rk.dma_ae = general_dma_engine_err_in || network_dma_engine_err_in;
   assign rk.nmi = 1'b0;
   assign rk.ubrk = decode_valid_in && user_break_in;
   assign rk.dbg = decode_valid_in && debug_host_port_irq_in;
   assign rk.ext = decode_valid_in && ext_irq_in && (ext_level_in > sr_q[7:4]);
   assign rk.peri = decode_valid_in && peri_irq_in && (peri_level_in > sr_q[7:4]);
   assign rk.trap = decode_valid_in && software_trap_op_in;
   assign rk.undef = decode_valid_in && undef_op_in;
   assign rk.in_slot = in_delay_slot_in;
   assign rk.pc_mod = pc_modify_op_in;
   assign clr_rise = chip_clear_input_n_in && !clr_q;
   // Trap enters while executing; others wait for the running insn
   assign take_now = (rk.pick == cxe_pkg::CXE_TRAP) || insn_done_in;

   // Level and vector number of the chosen source
   always_comb begin
      pick_lvl = sr_q[7:4];
      pick_vec = cxe_pkg::VEC_GEN_ILL;
      case (rk.pick)
         cxe_pkg::CXE_CPU_AE: pick_vec = cxe_pkg::VEC_CPU_AE;
         cxe_pkg::CXE_DMA_AE: pick_vec = cxe_pkg::VEC_DMA_AE;
         cxe_pkg::CXE_UBRK: pick_vec = cxe_pkg::VEC_UBRK;
         cxe_pkg::CXE_DBG: pick_vec = cxe_pkg::VEC_DBG;
         cxe_pkg::CXE_EXT: begin
            pick_vec = ext_vec_in;
            pick_lvl = ext_level_in;
         end
         cxe_pkg::CXE_PERI: begin
            pick_vec = peri_vec_in;
            pick_lvl = peri_level_in;
         end
         cxe_pkg::CXE_TRAP: pick_vec = trap_imm_in;
         cxe_pkg::CXE_SLOT_ILL: pick_vec = cxe_pkg::VEC_SLOT_ILL;
         default: pick_vec = cxe_pkg::VEC_GEN_ILL;
      endcase
   end

   // Clear pin history for edge detection
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         clr_q <= 1'b1;
      end else if (clk_en_in) begin
         clr_q <= chip_clear_input_n_in;
      end
   end

   // Entry sequencer
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_q <= ST_IDLE;
         por_q <= 1'b1;
         irq_q <= 1'b0;
         lvl_q <= 4'h0;
         vec_q <= 8'h00;
      end else if (clk_en_in) begin
         if (!chip_clear_input_n_in) begin
            state_q <= ST_WAIT;
         end else if (clr_rise) begin
            por_q <= nmi_pin_in;
            state_q <= ST_RST_PC;
         end else begin
            case (state_q)
               ST_IDLE: begin
                  if (nmi_pin_in && !clr_q) begin
                     state_q <= ST_IDLE;
                  end else if (rk.pick != cxe_pkg::CXE_NONE && take_now) begin
                     irq_q <= rk.pick inside {cxe_pkg::CXE_UBRK, cxe_pkg::CXE_DBG,
                        cxe_pkg::CXE_EXT, cxe_pkg::CXE_PERI};
                     lvl_q <= pick_lvl;
                     vec_q <= pick_vec;
                     state_q <= ST_PUSH_SR;
                  end
               end
               ST_WAIT: state_q <= ST_WAIT;
               ST_RST_PC: if (mem_done_in) state_q <= ST_RST_SP;
               ST_RST_SP: if (mem_done_in) state_q <= ST_GO;
               ST_PUSH_SR: if (mem_done_in) state_q <= ST_PUSH_PC;
               ST_PUSH_PC: if (mem_done_in) state_q <= ST_VEC;
               ST_VEC: if (mem_done_in) state_q <= ST_GO;
               ST_GO: state_q <= ST_IDLE;
               default: state_q <= ST_IDLE;
            endcase
         end
      end
   end

   // Captured return address, stack, fetched PC, base and status
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         sp_q <= 32'h0000_0000;
         pc_q <= 32'h0000_0000;
         ret_pc_q <= 32'h0000_0000;
         vbr_q <= cxe_pkg::VBR_RESET;
         sr_q <= cxe_pkg::SR_RESET;
      end else if (clk_en_in) begin
         if (state_q == ST_IDLE && rk.pick != cxe_pkg::CXE_NONE && take_now) begin
            sp_q <= stack_gpr_in - cxe_pkg::STACK_STEP;
            ret_pc_q <= cur_pc_in;
         end
         if (mem_done_in) begin
            case (state_q)
               ST_RST_PC: pc_q <= mem_rdata_in;
               ST_RST_SP: begin
                  sp_q <= mem_rdata_in;
                  vbr_q <= cxe_pkg::VBR_RESET;
                  sr_q[7:4] <= cxe_pkg::MASK_RESET;
               end
               ST_PUSH_SR: sp_q <= sp_q - cxe_pkg::STACK_STEP;
               ST_PUSH_PC: begin
                  if (irq_q) sr_q[7:4] <= lvl_q;
               end
               ST_VEC: pc_q <= mem_rdata_in;
               default: pc_q <= pc_q;
            endcase
         end
      end
   end

   // Memory request outputs, all registered
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_addr_out <= '0;
         mem_wdata_out <= 32'h0000_0000;
         mem_be_out <= 4'h0;
      end else if (clk_en_in) begin
         mem_req_out <= 1'b0;
         mem_we_out <= 1'b0;
         mem_be_out <= 4'hf;
         if (!(mem_done_in && mem_req_out) && chip_clear_input_n_in && !clr_rise) begin
            case (state_q)
               ST_RST_PC: begin
                  mem_req_out <= 1'b1;
                  mem_addr_out <= AW'(por_q ? cxe_pkg::POR_PC_ADDR : cxe_pkg::MAN_PC_ADDR);
               end
               ST_RST_SP: begin
                  mem_req_out <= 1'b1;
                  mem_addr_out <= AW'(por_q ? cxe_pkg::POR_SP_ADDR : cxe_pkg::MAN_SP_ADDR);
               end
               ST_PUSH_SR: begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b1;
                  mem_addr_out <= AW'(sp_q);
                  mem_wdata_out <= sr_q;
               end
               ST_PUSH_PC: begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b1;
                  mem_addr_out <= AW'(sp_q);
                  mem_wdata_out <= ret_pc_q;
               end
               ST_VEC: begin
                  mem_req_out <= 1'b1;
                  mem_addr_out <= AW'(vbr_q + {22'h000000, vec_q, 2'b00});
               end
               default: mem_req_out <= 1'b0;
            endcase
         end
      end
   end

   // Handover to the core
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         core_hold_out <= 1'b1;
         start_valid_out <= 1'b0;
         start_pc_out <= 32'h0000_0000;
         stack_gpr_out <= 32'h0000_0000;
         vector_base_reg_out <= cxe_pkg::VBR_RESET;
         processor_status_word_out <= cxe_pkg::SR_RESET;
         ack_out <= 1'b0;
      end else if (clk_en_in) begin
         core_hold_out <= (state_q != ST_IDLE) && (state_q != ST_GO);
         start_valid_out <= (state_q == ST_GO);
         start_pc_out <= pc_q;
         stack_gpr_out <= sp_q;
         vector_base_reg_out <= vbr_q;
         processor_status_word_out <= sr_q;
         ack_out <= (state_q == ST_PUSH_PC) && mem_done_in;
      end
   end
endmodule : cxe_entry

// ===== bench/cxe_entry_properties.sv
// Port checker of the exception entry unit
`timescale 1ns/10ps
module cxe_entry_properties #(
   parameter int AW = 32
) (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic chip_clear_input_n_in,
   input wire logic nmi_pin_in,
   input wire logic [31:0] stack_gpr_in,
   input wire logic mem_done_in,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [AW-1:0] mem_addr_out,
   input wire logic [3:0] mem_be_out,
   input wire logic start_valid_out,
   input wire logic [31:0] vector_base_reg_out,
   input wire logic [31:0] processor_status_word_out
);
   logic rst_seq_q;
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   // Marks a reset sequence from clear low until its start pulse
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) rst_seq_q <= 1'b0;
      else if (!chip_clear_input_n_in) rst_seq_q <= 1'b1;
      else if (start_valid_out) rst_seq_q <= 1'b0;
   end
   chk_por_vector: assert property (
      clk_en_in && nmi_pin_in && $rose(chip_clear_input_n_in) |->
      ##[1:2] mem_req_out && mem_addr_out == cxe_pkg::POR_PC_ADDR)
      else $error("power-on entry missed its PC vector");
   chk_man_vector: assert property (
      clk_en_in && !nmi_pin_in && $rose(chip_clear_input_n_in) |->
      ##[1:2] mem_req_out && mem_addr_out == cxe_pkg::MAN_PC_ADDR)
      else $error("manual entry missed its PC vector");
   chk_por_sp_next: assert property (
      rst_seq_q && mem_done_in && mem_addr_out == cxe_pkg::POR_PC_ADDR |->
      ##[1:2] mem_req_out && mem_addr_out == cxe_pkg::POR_SP_ADDR)
      else $error("stack vector read did not follow PC read");
   chk_req_hold: assert property (
      mem_req_out && !mem_done_in && !$past(mem_done_in) && chip_clear_input_n_in |=>
      mem_req_out && $stable(mem_addr_out) && $stable(mem_we_out))
      else $error("access dropped before completion");
   chk_word_access: assert property (
      mem_req_out |-> mem_be_out == 4'hf && mem_addr_out[1:0] == 2'h0)
      else $error("access not an aligned word");
   chk_reset_init: assert property (
      start_valid_out && rst_seq_q |-> vector_base_reg_out == cxe_pkg::VBR_RESET &&
      processor_status_word_out[7:4] == cxe_pkg::MASK_RESET)
      else $error("reset left base or mask wrong");
   chk_write_place: assert property (
      mem_req_out && mem_we_out |-> mem_addr_out == stack_gpr_in - 32'h4 ||
      mem_addr_out == stack_gpr_in - 32'h8)
      else $error("stack write outside the two save slots");
   chk_clear_abort: assert property (
      !chip_clear_input_n_in && clk_en_in |=> !mem_req_out && !start_valid_out)
      else $error("activity while clear held low");
   cover property (nmi_pin_in && $rose(chip_clear_input_n_in));
   cover property (!nmi_pin_in && $rose(chip_clear_input_n_in));
   cover property (mem_req_out && mem_we_out && mem_done_in);
endmodule : cxe_entry_properties

bind cxe_entry cxe_entry_properties #(.AW(AW)) u_props (.clk_in, .rst_in, .clk_en_in,
   .chip_clear_input_n_in, .nmi_pin_in, .stack_gpr_in, .mem_done_in, .mem_req_out,
   .mem_we_out, .mem_addr_out, .mem_be_out, .start_valid_out, .vector_base_reg_out,
   .processor_status_word_out);

// ===== bench/cxe_mem_model.sv
// Memory model answering reads with address-derived data and logging the last two stack writes
`timescale 1ns/10ps
module cxe_mem_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [1:0] lat_in,
   input wire logic mem_req_in,
   input wire logic mem_we_in,
   input wire logic [31:0] mem_addr_in,
   input wire logic [31:0] mem_wdata_in,
   output logic mem_done_out,
   output logic [31:0] mem_rdata_out
);
   logic [1:0] cnt_q;
   logic wi_q;
   logic [31:0] wa_q [2];
   logic [31:0] wd_q [2];
   // Answers each access after lat_in wait cycles, logs writes
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_q <= 2'h0;
         wi_q <= 1'b0;
         mem_done_out <= 1'b0;
         mem_rdata_out <= 32'h0;
      end else if (mem_done_out) begin
         mem_done_out <= 1'b0;
         mem_rdata_out <= ~mem_rdata_out; // Stale data is scrambled
      end else if (mem_req_in && cnt_q < lat_in) begin
         cnt_q <= cnt_q + 2'h1;
      end else if (mem_req_in) begin
         cnt_q <= 2'h0;
         mem_done_out <= 1'b1;
         mem_rdata_out <= {16'h3c00, mem_addr_in[15:0]};
         if (mem_we_in) begin
            wa_q[wi_q] <= mem_addr_in;
            wd_q[wi_q] <= mem_wdata_in;
            wi_q <= ~wi_q;
         end
      end
   end
endmodule : cxe_mem_model

// ===== bench/cxe_entry_tb.sv
// Self-checking bench of the exception entry unit
`timescale 1ns/10ps
module cxe_entry_tb;
   logic clk_in, rst_in, clk_en_in, chip_clear_input_n_in, nmi_pin_in, ext_irq_in;
   logic cpu_addr_err_in, general_dma_engine_err_in, network_dma_engine_err_in;
   logic user_break_in, debug_host_port_irq_in, peri_irq_in, decode_valid_in;
   logic insn_done_in, software_trap_op_in, undef_op_in, in_delay_slot_in, pc_modify_op_in;
   logic mem_done_in, mem_req_out, mem_we_out, core_hold_out, start_valid_out, ack_out;
   logic [3:0] ext_level_in, peri_level_in, mem_be_out;
   logic [7:0] ext_vec_in, peri_vec_in, trap_imm_in;
   logic [31:0] cur_pc_in, stack_gpr_in, mem_rdata_in, mem_addr_out, mem_wdata_out;
   logic [31:0] start_pc_out, stack_gpr_out, vector_base_reg_out, processor_status_word_out;
   logic [9:0] rq;
   logic [1:0] lat;
   int errors, cmp_count, n, acks;
   assign {cpu_addr_err_in, general_dma_engine_err_in, network_dma_engine_err_in,
      user_break_in, debug_host_port_irq_in, ext_irq_in, software_trap_op_in,
      undef_op_in, in_delay_slot_in, pc_modify_op_in} = rq;
   cxe_entry uut (.clk_in, .rst_in, .clk_en_in, .chip_clear_input_n_in, .nmi_pin_in,
      .cpu_addr_err_in, .general_dma_engine_err_in, .network_dma_engine_err_in,
      .user_break_in, .debug_host_port_irq_in, .ext_irq_in, .ext_level_in, .ext_vec_in,
      .peri_irq_in, .peri_level_in, .peri_vec_in, .decode_valid_in, .insn_done_in,
      .software_trap_op_in, .trap_imm_in, .undef_op_in, .in_delay_slot_in,
      .pc_modify_op_in, .cur_pc_in, .stack_gpr_in, .mem_done_in, .mem_rdata_in,
      .mem_req_out, .mem_we_out, .mem_addr_out, .mem_wdata_out, .mem_be_out,
      .core_hold_out, .start_valid_out, .start_pc_out, .stack_gpr_out,
      .vector_base_reg_out, .processor_status_word_out, .ack_out);
   cxe_mem_model mdl (.clk_in, .rst_in, .lat_in(lat), .mem_req_in(mem_req_out),
      .mem_we_in(mem_we_out), .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
      .mem_done_out(mem_done_in), .mem_rdata_out(mem_rdata_in));
   // Counts save-complete pulses, looked at mid-cycle
   always @(negedge clk_in) begin
      if (ack_out === 1'b1) acks++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic wait_start;
      for (n = 0; n < 40 && start_valid_out !== 1'b1; n++) begin
         @(posedge clk_in);
         #1;
      end
   endtask : wait_start
   task automatic do_reset(input logic nm, input logic [31:0] pa, input logic [31:0] sa);
      @(negedge clk_in);
      chip_clear_input_n_in = 1'b0;
      nmi_pin_in = nm;
      repeat (3) @(negedge clk_in);
      chk(core_hold_out, 1'b1);
      chip_clear_input_n_in = 1'b1;
      wait_start();
      chk(core_hold_out, 1'b0);
      chk(start_pc_out, {16'h3c00, pa[15:0]});
      chk(stack_gpr_out, {16'h3c00, sa[15:0]});
      chk(vector_base_reg_out, 32'h0);
      chk(processor_status_word_out[7:4], 4'hf);
      @(negedge clk_in);
      nmi_pin_in = 1'b1;
      $display("reset test done");
   endtask : do_reset
   task automatic entry(input logic [9:0] r, input logic [7:0] v);
      int a0;
      a0 = acks;
      @(negedge clk_in);
      rq = r;
      decode_valid_in = 1'b1;
      if (!r[3]) begin
         repeat (3) @(negedge clk_in);
         chk(mem_req_out, 1'b0);
         insn_done_in = 1'b1;
         @(negedge clk_in);
         insn_done_in = 1'b0;
      end
      wait_start();
      chk(start_valid_out, v != 8'h0);
      if (v != 8'h0) chk(start_pc_out, {16'h3c00, 6'h0, v, 2'h0});
      chk(acks - a0, v != 8'h0);
      @(negedge clk_in);
      rq = 10'h0;
      decode_valid_in = 1'b0;
      repeat (2) @(negedge clk_in);
   endtask : entry
   task automatic t_stack;
      lat = 2'h3;
      entry(10'b0000000100, cxe_pkg::VEC_GEN_ILL);
      chk(mdl.wa_q[0], 32'h0ffc);
      chk(mdl.wd_q[0], cxe_pkg::SR_RESET);
      chk(mdl.wa_q[1], 32'h0ff8);
      chk(mdl.wd_q[1], cur_pc_in);
      chk(processor_status_word_out[7:4], 4'hf);
      $display("stack test done");
   endtask : t_stack
   task automatic t_rank;
      lat = 2'h0;
      entry(10'b1101000100, cxe_pkg::VEC_CPU_AE);
      entry(10'b0101100000, cxe_pkg::VEC_DMA_AE);
      entry(10'b0010000100, cxe_pkg::VEC_DMA_AE);
      entry(10'b0001110100, cxe_pkg::VEC_UBRK);
      entry(10'b0000100100, cxe_pkg::VEC_DBG);
      entry(10'b0000001100, 8'h21);
      entry(10'b0000000110, cxe_pkg::VEC_SLOT_ILL);
      entry(10'b0000000011, cxe_pkg::VEC_SLOT_ILL);
      $display("rank test done");
   endtask : t_rank
   task automatic t_refuse;
      peri_irq_in = 1'b1;
      entry(10'b0000010000, 8'h0);
      peri_irq_in = 1'b0;
      $display("refuse test done");
   endtask : t_refuse
   // Clear rise while frozen must be kept and acted on once enabled
   task automatic t_freeze;
      @(negedge clk_in);
      chip_clear_input_n_in = 1'b0;
      repeat (2) @(negedge clk_in);
      chip_clear_input_n_in = 1'b1;
      clk_en_in = 1'b0;
      repeat (5) @(negedge clk_in);
      chk(mem_req_out, 1'b0);
      chk(core_hold_out, 1'b1);
      chk(start_valid_out, 1'b0);
      clk_en_in = 1'b1;
      wait_start();
      chk(start_pc_out, {16'h3c00, cxe_pkg::POR_PC_ADDR[15:0]});
      chk(stack_gpr_out, {16'h3c00, cxe_pkg::POR_SP_ADDR[15:0]});
      @(negedge clk_in);
      $display("freeze test done");
   endtask : t_freeze
   // Clock at 20 MHz
   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end
   // Watchdog
   initial begin
      #1000000;
      errors++;
      close_out();
   end
   // Main sequence
   initial begin
      {errors, cmp_count, acks, rq, lat} = '0;
      {rst_in, clk_en_in, nmi_pin_in, chip_clear_input_n_in} = 4'b1110;
      {peri_irq_in, decode_valid_in, insn_done_in} = 3'h0;
      ext_level_in = 4'hf;
      peri_level_in = 4'h3;
      {ext_vec_in, peri_vec_in, trap_imm_in} = {8'h40, 8'h50, 8'h21};
      cur_pc_in = 32'h2468;
      stack_gpr_in = 32'h1000;
      repeat (2) @(negedge clk_in);
      rst_in = 1'b0;
      do_reset(1'b1, cxe_pkg::POR_PC_ADDR, cxe_pkg::POR_SP_ADDR);
      lat = 2'h3;
      do_reset(1'b0, cxe_pkg::MAN_PC_ADDR, cxe_pkg::MAN_SP_ADDR);
      t_stack();
      t_rank();
      t_refuse();
      t_freeze();
      close_out();
   end
endmodule : cxe_entry_tb
